// File: rtl/ocf_pkg.sv
package ocf_pkg;
	// clock and delay-unit timing
	localparam int CLK_PERIOD_NS   = 4;
	localparam int DLY_UNIT_NS_DEF = 1000;
	// quarter of a 100 kHz serial bit time
	localparam int SMB_QTR_NS  = 2500;
	localparam int SMB_QTR_CYC = SMB_QTR_NS / CLK_PERIOD_NS;
	localparam logic [9:0] SMB_QTR_LD = 10'(SMB_QTR_CYC - 1);

	// response field codes
	localparam logic [1:0] RSP_CC    = 2'h0;
	localparam logic [1:0] RSP_UV    = 2'h1;
	localparam logic [1:0] RSP_TIMED = 2'h2;
	localparam logic [1:0] RSP_SHUT  = 2'h3;
	// retry field codes
	localparam logic [2:0] RTY_NONE    = 3'h0;
	localparam logic [2:0] RTY_FOREVER = 3'h7;
	// response setting reset value: shut down, no retry
	localparam logic [7:0] RESP_RST = 8'hc0;
	// fixed host address of the direct notice
	localparam logic [6:0] HOST_ADDR = 7'h08;
	// notification method selection
	localparam logic [1:0] NTF_NONE   = 2'h0;
	localparam logic [1:0] NTF_ALERT  = 2'h1;
	localparam logic [1:0] NTF_DIRECT = 2'h2;

	// response setting byte layout
	typedef struct packed {
		logic [1:0] rsp;
		logic [2:0] rty;
		logic [2:0] dly;
	} ocf_resp_t;

	// contents of one direct notice
	typedef struct packed {
		logic [6:0]  addr;
		logic        xbit;
		logic [15:0] status;
	} ocf_pkt_t;

	typedef enum logic [6:0] {
		ST_RUN   = 7'h01,
		ST_LIMIT = 7'h02,
		ST_SHUT  = 7'h04,
		ST_WAIT  = 7'h08,
		ST_RETRY = 7'h10,
		ST_LATCH = 7'h20,
		ST_OFF   = 7'h40
	} ocf_state_t;

	typedef enum logic [3:0] {
		N_IDLE  = 4'h1,
		N_START = 4'h2,
		N_BIT   = 4'h4,
		N_STOP  = 4'h8
	} ocf_nst_t;
endpackage

// File: rtl/ocf_notify.sv
`timescale 1ns/1ps
module ocf_notify
	import ocf_pkg::*;
(
	input  wire logic     core_clk_i,
	input  wire logic     rst_i,
	input  wire logic     start_i,
	input  wire ocf_pkt_t pkt_i,
	input  wire logic     scl_i,
	input  wire logic     sda_i,
	output logic          scl_oe_o,
	output logic          sda_oe_o,
	output logic          busy_o,
	output logic          nack_o
);
	ocf_nst_t    st_ff;
	logic [1:0]  q_ff;
	logic [9:0]  cnt_ff;
	logic [3:0]  bit_ff;
	logic [1:0]  byte_ff;
	logic [31:0] sh_ff;
	logic        scl_oe_ff;
	logic        sda_oe_ff;
	logic        nack_ff;
	logic [1:0]  scl_sync_ff;
	logic [1:0]  sda_sync_ff;
	logic        stall;
	logic        tick;

	// two-stage synchronisers for the bus lines
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			scl_sync_ff <= 2'h3;
			sda_sync_ff <= 2'h3;
		end else begin
			scl_sync_ff <= {scl_sync_ff[0], scl_i};
			sda_sync_ff <= {sda_sync_ff[0], sda_i};
		end
	end

	// a released clock held low by the host stretches the quarter
	assign stall = !scl_oe_ff && !scl_sync_ff[1];
	assign tick  = (cnt_ff == 10'h000) && !stall;

	// quarter-bit timer
	always_ff @(posedge core_clk_i) begin
		if (rst_i || st_ff == N_IDLE)
			cnt_ff <= SMB_QTR_LD;
		else if (tick)
			cnt_ff <= SMB_QTR_LD;
		else if (!stall)
			cnt_ff <= cnt_ff - 10'h001;
	end

	// start, four bytes with host acknowledge each, stop
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			st_ff     <= N_IDLE;
			q_ff      <= 2'h0;
			bit_ff    <= 4'h0;
			byte_ff   <= 2'h0;
			sh_ff     <= 32'h0;
			scl_oe_ff <= 1'b0;
			sda_oe_ff <= 1'b0;
			nack_ff   <= 1'b0;
		end else begin
			unique case (st_ff)
			N_IDLE: if (start_i) begin
				// host address and write, then own address, low, high
				sh_ff     <= {HOST_ADDR, 1'b0, pkt_i.addr, pkt_i.xbit,
					pkt_i.status[7:0], pkt_i.status[15:8]};
				sda_oe_ff <= 1'b1; // start: data falls while clock high
				nack_ff   <= 1'b0;
				byte_ff   <= 2'h0;
				bit_ff    <= 4'h0;
				q_ff      <= 2'h0;
				st_ff     <= N_START;
			end
			N_START: if (tick) begin
				scl_oe_ff <= 1'b1;
				sda_oe_ff <= !sh_ff[31];
				st_ff     <= N_BIT;
			end
			N_BIT: if (tick) begin
				q_ff <= q_ff + 2'h1;
				unique case (q_ff)
				2'h0: scl_oe_ff <= 1'b0;
				2'h1: ;
				2'h2: begin
					scl_oe_ff <= 1'b1;
					if (bit_ff == 4'h8 && sda_sync_ff[1])
						nack_ff <= 1'b1; // host must pull data low
				end
				2'h3: if (bit_ff == 4'h8) begin
					if (nack_ff || byte_ff == 2'h3) begin
						sda_oe_ff <= 1'b1;
						st_ff     <= N_STOP;
					end else begin
						byte_ff   <= byte_ff + 2'h1;
						bit_ff    <= 4'h0;
						sda_oe_ff <= !sh_ff[31];
					end
				end else begin
					bit_ff    <= bit_ff + 4'h1;
					sh_ff     <= sh_ff << 1;
					sda_oe_ff <= (bit_ff == 4'h7) ? 1'b0 : !sh_ff[30];
				end
				endcase
			end
			N_STOP: if (tick) begin
				q_ff <= q_ff + 2'h1;
				if (q_ff == 2'h0)
					scl_oe_ff <= 1'b0;
				else begin
					sda_oe_ff <= 1'b0; // stop: data rises while clock high
					st_ff     <= N_IDLE;
				end
			end
			endcase
		end
	end

	assign scl_oe_o = scl_oe_ff;
	assign sda_oe_o = sda_oe_ff;
	assign busy_o   = (st_ff != N_IDLE);
	assign nack_o   = nack_ff;
endmodule // ocf_notify

// File: rtl/ocf_fault_resp.sv
`timescale 1ns/1ps
module ocf_fault_resp
	import ocf_pkg::*;
#(
	parameter int         DLY_UNIT_NS = DLY_UNIT_NS_DEF,
	parameter logic [1:0] NOTIFY_MODE = NTF_DIRECT
)(
	input  wire logic        core_clk_i,
	input  wire logic        rst_i,
	input  wire logic        resp_wr_i,
	input  wire logic [7:0]  resp_wdata_i,
	output logic      [7:0]  resp_rdata_o,
	input  wire logic        oc_det_i,
	input  wire logic        uv_det_i,
	input  wire logic        out_ok_i,
	input  wire logic        on_cmd_i,
	input  wire logic        other_fault_i,
	input  wire logic        fault_clr_i,
	input  wire logic [6:0]  dev_addr_i,
	input  wire logic        dev_xbit_i,
	input  wire logic [15:0] status_word_i,
	output logic             out_en_o,
	output logic             cur_limit_o,
	output logic             oc_fault_o,
	output logic      [2:0]  retry_cnt_o,
	output logic             alert_oe_o,
	input  wire logic        scl_i,
	output logic             scl_o,
	output logic             scl_oe_o,
	input  wire logic        sda_i,
	output logic             sda_o,
	output logic             sda_oe_o,
	output logic             ntf_busy_o,
	output logic             ntf_nack_o
);
	// cycles per delay unit, least time so rounded up
	localparam int UNIT_CYC = (DLY_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [31:0] UNIT_CYC_W = 32'(UNIT_CYC);

	ocf_resp_t   cfg_ff;
	ocf_state_t  st_ff;
	ocf_state_t  nxt_st;
	logic [4:0]  pin_sync0_ff;
	logic [4:0]  pin_sync1_ff;
	logic [31:0] tmr_ff;
	logic [2:0]  att_ff;
	logic        oc_fault_ff;
	logic        alert_ff;
	logic        tmr_load;
	logic        att_inc;
	logic        att_clr;
	logic        tmr_done;
	logic        fault_new;
	logic        oc_s;
	logic        uv_s;
	logic        ok_s;
	logic        on_s;
	logic        oth_s;
	logic        nb_scl_oe;
	logic        nb_sda_oe;
	logic        nb_busy;
	logic        nb_nack;

	// delay field in clock cycles
	function automatic logic [31:0] dly_cyc(input logic [2:0] d);
		dly_cyc = 32'(d) * UNIT_CYC_W;
	endfunction

	// analog comparators and control pin cross in through two flops
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			pin_sync0_ff <= 5'h00;
			pin_sync1_ff <= 5'h00;
		end else begin
			pin_sync0_ff <= {oc_det_i, uv_det_i, out_ok_i, on_cmd_i,
				other_fault_i};
			pin_sync1_ff <= pin_sync0_ff;
		end
	end
	assign {oc_s, uv_s, ok_s, on_s, oth_s} = pin_sync1_ff;

	// response setting register
	always_ff @(posedge core_clk_i) begin
		if (rst_i)
			cfg_ff <= RESP_RST;
		else if (resp_wr_i)
			cfg_ff <= resp_wdata_i;
	end

	// sticky fault bit: a new fault wins over a clear in the same cycle
	assign fault_new = oc_s && !oc_fault_ff;
	always_ff @(posedge core_clk_i) begin
		if (rst_i)
			oc_fault_ff <= 1'b0;
		else if (oc_s)
			oc_fault_ff <= 1'b1;
		else if (fault_clr_i)
			oc_fault_ff <= 1'b0;
	end

	// delay timer, loaded at each run-time or retry interval start
	assign tmr_done = (tmr_ff == 32'h0);
	always_ff @(posedge core_clk_i) begin
		if (rst_i || att_clr)
			tmr_ff <= 32'h0;
		else if (tmr_load)
			tmr_ff <= dly_cyc(cfg_ff.dly);
		else if (!tmr_done)
			tmr_ff <= tmr_ff - 32'h1;
	end

	// restart attempt counter, saturates for unlimited retry
	always_ff @(posedge core_clk_i) begin
		if (rst_i || att_clr)
			att_ff <= 3'h0;
		else if (att_inc && att_ff != 3'h7)
			att_ff <= att_ff + 3'h1;
	end

	// fault reaction sequencer
	always_comb begin
		nxt_st   = st_ff;
		tmr_load = 1'b0;
		att_inc  = 1'b0;
		att_clr  = 1'b0;
		unique case (st_ff)
		ST_OFF: if (on_s) begin
			nxt_st  = ST_RUN;
			att_clr = 1'b1;
		end
		ST_RUN: if (oc_s) begin
			tmr_load = 1'b1;
			nxt_st   = (cfg_ff.rsp == RSP_SHUT) ? ST_SHUT : ST_LIMIT;
		end
		ST_LIMIT: begin
			if (!oc_s)
				nxt_st = ST_RUN;
			else if ((cfg_ff.rsp == RSP_UV && uv_s) ||
				(cfg_ff.rsp == RSP_TIMED && tmr_done) ||
				cfg_ff.rsp == RSP_SHUT)
				nxt_st = ST_SHUT;
		end
		ST_SHUT: if (cfg_ff.rty == RTY_NONE)
			nxt_st = ST_LATCH;
		else begin
			nxt_st   = ST_WAIT;
			tmr_load = 1'b1;
		end
		ST_WAIT, ST_RETRY: begin
			if (st_ff == ST_RETRY && ok_s && !oc_s) begin
				nxt_st  = ST_RUN; // restart succeeded
				att_clr = 1'b1;
			end else if (tmr_done) begin
				if (cfg_ff.rty == RTY_FOREVER || att_ff < cfg_ff.rty) begin
					nxt_st   = ST_RETRY;
					tmr_load = 1'b1;
					att_inc  = 1'b1;
				end else
					nxt_st = ST_LATCH;
			end else if (st_ff == ST_RETRY && oc_s)
				nxt_st = ST_WAIT; // attempt failed, off until next start
		end
		ST_LATCH: ;
		endcase
		if (oth_s && st_ff != ST_OFF)
			nxt_st = ST_LATCH;
		if (!on_s)
			nxt_st = ST_OFF;
	end

	// state register, output off after reset
	always_ff @(posedge core_clk_i) begin
		if (rst_i)
			st_ff <= ST_OFF;
		else
			st_ff <= nxt_st;
	end

	// alert line held until the next fault clear request
	always_ff @(posedge core_clk_i) begin
		if (rst_i)
			alert_ff <= 1'b0;
		else if (NOTIFY_MODE != NTF_ALERT)
			alert_ff <= 1'b0;
		else if (fault_new)
			alert_ff <= 1'b1;
		else if (fault_clr_i)
			alert_ff <= 1'b0;
	end

	// direct notice master, started on each new fault that finds it idle
	ocf_notify u_notify (
		.core_clk_i (core_clk_i),
		.rst_i      (rst_i),
		.start_i    (fault_new && NOTIFY_MODE == NTF_DIRECT),
		.pkt_i      ({dev_addr_i, dev_xbit_i, status_word_i}),
		.scl_i      (scl_i),
		.sda_i      (sda_i),
		.scl_oe_o   (nb_scl_oe),
		.sda_oe_o   (nb_sda_oe),
		.busy_o     (nb_busy),
		.nack_o     (nb_nack)
	);

	// output enable and limit flag follow the one-hot state bits
	assign out_en_o     = st_ff == ST_RUN || st_ff == ST_LIMIT ||
		st_ff == ST_RETRY;
	assign cur_limit_o  = (st_ff == ST_LIMIT);
	assign oc_fault_o   = oc_fault_ff;
	assign retry_cnt_o  = att_ff;
	assign resp_rdata_o = cfg_ff;
	assign alert_oe_o   = alert_ff;
	assign scl_o        = 1'b0;
	assign sda_o        = 1'b0;
	assign scl_oe_o     = nb_scl_oe;
	assign sda_oe_o     = nb_sda_oe;
	assign ntf_busy_o   = nb_busy;
	assign ntf_nack_o   = nb_nack;

	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (rst_i);

	chk_fault_set: assert property (oc_s |=> oc_fault_o)
		else $error("fault bit not set");
	chk_fault_hold: assert property (
		oc_fault_o && !fault_clr_i |=> oc_fault_o)
		else $error("fault bit dropped without clear");
	chk_cc_limit: assert property (
		st_ff == ST_LIMIT && cfg_ff.rsp == RSP_CC && oc_s && on_s &&
		!oth_s && !resp_wr_i |=> cur_limit_o && out_en_o)
		else $error("constant current limit left");
	chk_uv_shut: assert property (
		st_ff == ST_LIMIT && cfg_ff.rsp == RSP_UV && oc_s && uv_s && on_s &&
		!oth_s |=> st_ff == ST_SHUT)
		else $error("no shutdown below voltage floor");
	chk_timed_load: assert property (
		$rose(st_ff == ST_LIMIT) |-> tmr_ff == dly_cyc(cfg_ff.dly))
		else $error("timed limit not loaded");
	chk_shut_now: assert property (
		st_ff == ST_RUN && cfg_ff.rsp == RSP_SHUT && oc_s && on_s &&
		!oth_s && !resp_wr_i |=> !out_en_o ##1 !out_en_o)
		else $error("no immediate shutdown");
	chk_no_retry: assert property (
		st_ff == ST_SHUT && cfg_ff.rty == RTY_NONE && on_s && !oth_s
		|=> st_ff == ST_LATCH)
		else $error("restart with retry zero");
	chk_retry_bound: assert property (
		st_ff == ST_RETRY && cfg_ff.rty != RTY_FOREVER && !$past(resp_wr_i)
		|-> att_ff != 3'h0 && att_ff <= cfg_ff.rty)
		else $error("too many restarts");
	chk_latch_hold: assert property (
		st_ff == ST_LATCH && on_s |=> !out_en_o)
		else $error("latched output came back");
	chk_clear_fresh: assert property (
		st_ff == ST_OFF && on_s |=> st_ff == ST_RUN && att_ff == 3'h0 &&
		tmr_ff == 32'h0)
		else $error("retry state not cleared");
	chk_one_method: assert property (
		!(alert_oe_o && ntf_busy_o))
		else $error("both notification methods used");

	cov_retry_ok: cover property (st_ff == ST_RETRY ##1 st_ff == ST_RUN);
	cov_latched: cover property (st_ff == ST_WAIT ##1 st_ff == ST_LATCH);
	cov_notice: cover property ($rose(ntf_busy_o));
endmodule // ocf_fault_resp

// File: bench/ocf_host_model.sv
`timescale 1ns/1ps
// bus host that takes a device-sent notice and acks every byte
module ocf_host_model #(
	parameter int STRETCH_NS = 3000
)(
	input  wire logic        scl_i,
	input  wire logic        sda_i,
	output logic             scl_low_o,
	output logic             sda_low_o,
	output logic      [31:0] bytes_o,
	output int               nbytes_o
);
	int         bitc;
	logic [7:0] sh;
	logic       scl_q;
	logic       sda_q;
	// one process follows both lines, so every variable has one writer
	initial begin
		scl_low_o = 1'b0;
		sda_low_o = 1'b0;
		bytes_o   = 32'h0;
		nbytes_o  = 0;
		bitc      = 0;
		sh        = 8'h00;
		scl_q     = 1'b1;
		sda_q     = 1'b1;
		forever begin
			@(scl_i or sda_i);
			if (scl_q && scl_i && sda_q && !sda_i) begin
				// start condition opens a fresh packet
				bitc     = 0;
				nbytes_o = 0;
			end else if (!scl_q && scl_i) begin
				// data bits are taken while the clock is high
				if (bitc < 8)
					sh = {sh[6:0], sda_i};
				bitc = bitc + 1;
			end else if (scl_q && !scl_i) begin
				// ack each byte, then stretch the clock a little
				if (bitc == 8) begin
					sda_low_o = 1'b1;
					if (nbytes_o < 4)
						bytes_o[8*nbytes_o +: 8] = sh;
					nbytes_o = nbytes_o + 1;
				end else if (bitc == 9) begin
					sda_low_o = 1'b0;
					bitc      = 0;
					scl_low_o = 1'b1;
					#STRETCH_NS;
					scl_low_o = 1'b0;
				end
			end
			// lines may have moved while the clock was stretched
			scl_q = scl_i;
			sda_q = sda_i;
		end
	end
endmodule // ocf_host_model

// File: bench/test_overcurrent_fault_response.sv
`timescale 1ns/1ps
module test_overcurrent_fault_response;
	import ocf_pkg::*;
	logic        core_clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        resp_wr_i = 1'b0;
	logic [7:0]  resp_wdata_i = 8'h00;
	logic        oc = 1'b0, uv = 1'b0, ok = 1'b1, on = 1'b0, oth = 1'b0;
	logic        clr = 1'b0;
	logic [7:0]  rdata;
	logic        en, lim, flt, alert, scl_oe, sda_oe, busy, nack;
	logic [2:0]  rcnt;
	logic        scl, sda, h_scl, h_sda;
	logic [31:0] hbytes;
	int          hn;
	int          fail_count = 0;
	int          n_checks = 0;
	// wired-and bus lines with pull-ups
	assign scl = !(scl_oe | h_scl);
	assign sda = !(sda_oe | h_sda);
	always #2 core_clk_i = ~core_clk_i;
	ocf_fault_resp #(.DLY_UNIT_NS(20), .NOTIFY_MODE(NTF_DIRECT)) dut (
		.core_clk_i(core_clk_i), .rst_i(rst_i), .resp_wr_i(resp_wr_i),
		.resp_wdata_i(resp_wdata_i), .resp_rdata_o(rdata),
		.oc_det_i(oc), .uv_det_i(uv), .out_ok_i(ok), .on_cmd_i(on),
		.other_fault_i(oth), .fault_clr_i(clr), .dev_addr_i(7'h5a),
		.dev_xbit_i(1'b1), .status_word_i(16'h1234), .out_en_o(en),
		.cur_limit_o(lim), .oc_fault_o(flt), .retry_cnt_o(rcnt),
		.alert_oe_o(alert), .scl_i(scl), .scl_o(), .scl_oe_o(scl_oe),
		.sda_i(sda), .sda_o(), .sda_oe_o(sda_oe), .ntf_busy_o(busy),
		.ntf_nack_o(nack));
	ocf_host_model host (.scl_i(scl), .sda_i(sda), .scl_low_o(h_scl),
		.sda_low_o(h_sda), .bytes_o(hbytes), .nbytes_o(hn));
	task automatic stop_test();
		$display("checks %0d, mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic step(int n);
		repeat (n) @(posedge core_clk_i);
		#1;
	endtask
	// bounded wait for the output enable to reach a level
	task automatic wait_en(logic v);
		int n;
		n = 0;
		while (en !== v && n < 300) begin
			step(1);
			n++;
		end
		if (n == 300) begin
			fail_count++;
			stop_test();
		end
	endtask
	task automatic set_resp(logic [7:0] v);
		resp_wr_i = 1'b1;
		resp_wdata_i = v;
		step(1);
		resp_wr_i = 1'b0;
		step(1);
		check("resp_rdata", rdata, v);
	endtask
	// command off then on again
	task automatic restart();
		oc = 1'b0;
		uv = 1'b0;
		on = 1'b0;
		step(5);
		on = 1'b1;
		step(5);
		check("out_en_restart", en, 1'b1);
		check("retry_cnt_clr", rcnt, 3'h0);
	endtask
	task automatic t_retry_timing();
		int n;
		set_resp(8'hd2);
		oc = 1'b1;
		wait_en(1'b0);
		oc = 1'b0;
		check("oc_fault", flt, 1'b1);
		n = 0;
		while (en === 1'b0 && n < 100) begin
			step(1);
			n++;
		end
		check("off_cycles", n, 2 * 5 + 2);
		if (n == 100)
			stop_test();
		check("retry_cnt", rcnt, 3'h1);
		check("ntf_busy", busy, 1'b1);
		step(3);
		check("retry_cnt_ok", rcnt, 3'h0);
		check("oc_fault_sticky", flt, 1'b1);
	endtask
	task automatic t_exhaust();
		set_resp(8'hc9);
		ok = 1'b0;
		oc = 1'b1;
		wait_en(1'b0);
		oc = 1'b0;
		step(60);
		check("latched_off", en, 1'b0);
		check("retry_used", rcnt, 3'h1);
		ok = 1'b1;
		restart();
	endtask
	task automatic t_no_retry();
		set_resp(8'hc1);
		oc = 1'b1;
		wait_en(1'b0);
		oc = 1'b0;
		step(40);
		check("no_retry_off", en, 1'b0);
		check("no_retry_cnt", rcnt, 3'h0);
		restart();
	endtask
	task automatic t_forever();
		set_resp(8'hf9);
		ok = 1'b0;
		oc = 1'b1;
		step(120);
		check("retry_sat", rcnt, 3'h7);
		oth = 1'b1;
		step(10);
		oth = 1'b0;
		step(30);
		check("other_fault_off", en, 1'b0);
		ok = 1'b1;
		restart();
	endtask
	task automatic t_limits();
		set_resp(8'h01);
		oc = 1'b1;
		uv = 1'b1;
		step(50);
		check("cc_en", en, 1'b1);
		check("cc_limit", lim, 1'b1);
		oc = 1'b0;
		uv = 1'b0;
		step(5);
		check("cc_release", lim, 1'b0);
		set_resp(8'h41);
		oc = 1'b1;
		step(10);
		check("uv_limit", lim, 1'b1);
		uv = 1'b1;
		step(6);
		check("uv_shut", en, 1'b0);
		restart();
		set_resp(8'h83);
		oc = 1'b1;
		step(8);
		check("timed_en", en, 1'b1);
		check("timed_limit", lim, 1'b1);
		step(25);
		check("timed_shut", en, 1'b0);
		restart();
	endtask
	task automatic t_notice();
		int n;
		n = 0;
		while (busy !== 1'b0 && n < 99000) begin
			step(1);
			n++;
		end
		if (n == 99000) begin
			fail_count++;
			stop_test();
		end
		check("ntf_bytes", hn, 4);
		check("host_byte", hbytes[7:0], {HOST_ADDR, 1'b0});
		check("addr_byte", hbytes[15:8], {7'h5a, 1'b1});
		check("status_word", hbytes[31:16], 16'h1234);
		check("ntf_nack", nack, 1'b0);
		check("alert_unused", alert, 1'b0);
		clr = 1'b1;
		step(2);
		clr = 1'b0;
		step(2);
		check("oc_fault_clr", flt, 1'b0);
	endtask
	initial begin
		step(20);
		rst_i = 1'b0;
		check("rst_resp", rdata, RESP_RST);
		check("rst_en", en, 1'b0);
		check("rst_flt", flt, 1'b0);
		on = 1'b1;
		step(5);
		check("on_en", en, 1'b1);
		t_retry_timing();
		t_exhaust();
		t_no_retry();
		t_forever();
		t_limits();
		t_notice();
		stop_test();
	end
endmodule // test_overcurrent_fault_response
